// ### rtl/i2cbr_top.sv
`timescale 1ns/1ns
// Overview of operation
// - clock and data lines are open-drain: driven low or released, and sensed.
// - own slave address stored; matching calling address gets acknowledged as slave.
// - divider bits 7:6 pick multiplier: 00 one, 01 two, 10 four.
// - divider bits 5:0 select both clock divider and data hold count.
// - bit rate equals bus clock over multiplier times selected divider.
// - after clock falls, wait hold count bus cycles before changing data.
// - 64 index codes map to fixed divider and hold pairs per lookup.
module i2cbr_top
    import i2cbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);

    i2cbr_regs_t r;
    i2cbr_regs_t next_r;
    i2cbr_rate_t rate;
    logic [1:0] multiplier_select_sel;
    logic [13:0] period;
    logic [13:0] half;
    logic acc;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    function automatic i2cbr_rate_t rate_lut(input logic [5:0] idx);
        case (idx)
            6'h00: rate_lut = {12'd20, 10'd7};
            6'h01: rate_lut = {12'd22, 10'd7};
            6'h02: rate_lut = {12'd24, 10'd8};
            6'h03: rate_lut = {12'd26, 10'd8};
            6'h04: rate_lut = {12'd28, 10'd9};
            6'h05: rate_lut = {12'd30, 10'd9};
            6'h06: rate_lut = {12'd34, 10'd10};
            6'h07: rate_lut = {12'd40, 10'd10};
            6'h08: rate_lut = {12'd28, 10'd7};
            6'h09: rate_lut = {12'd32, 10'd7};
            6'h0a: rate_lut = {12'd36, 10'd9};
            6'h0b: rate_lut = {12'd40, 10'd9};
            6'h0c: rate_lut = {12'd44, 10'd11};
            6'h0d: rate_lut = {12'd48, 10'd11};
            6'h0e: rate_lut = {12'd56, 10'd13};
            6'h0f: rate_lut = {12'd68, 10'd13};
            6'h10: rate_lut = {12'd48, 10'd9};
            6'h11: rate_lut = {12'd56, 10'd9};
            6'h12: rate_lut = {12'd64, 10'd13};
            6'h13: rate_lut = {12'd72, 10'd13};
            6'h14: rate_lut = {12'd80, 10'd17};
            6'h15: rate_lut = {12'd88, 10'd17};
            6'h16: rate_lut = {12'd104, 10'd21};
            6'h17: rate_lut = {12'd128, 10'd21};
            6'h18: rate_lut = {12'd80, 10'd9};
            6'h19: rate_lut = {12'd96, 10'd9};
            6'h1a: rate_lut = {12'd112, 10'd17};
            6'h1b: rate_lut = {12'd128, 10'd17};
            6'h1c: rate_lut = {12'd144, 10'd25};
            6'h1d: rate_lut = {12'd160, 10'd25};
            6'h1e: rate_lut = {12'd192, 10'd33};
            6'h1f: rate_lut = {12'd240, 10'd33};
            6'h20: rate_lut = {12'd160, 10'd17};
            6'h21: rate_lut = {12'd192, 10'd17};
            6'h22: rate_lut = {12'd224, 10'd33};
            6'h23: rate_lut = {12'd256, 10'd33};
            6'h24: rate_lut = {12'd288, 10'd49};
            6'h25: rate_lut = {12'd320, 10'd49};
            6'h26: rate_lut = {12'd384, 10'd65};
            6'h27: rate_lut = {12'd480, 10'd65};
            6'h28: rate_lut = {12'd320, 10'd33};
            6'h29: rate_lut = {12'd384, 10'd33};
            6'h2a: rate_lut = {12'd448, 10'd65};
            6'h2b: rate_lut = {12'd512, 10'd65};
            6'h2c: rate_lut = {12'd576, 10'd97};
            6'h2d: rate_lut = {12'd640, 10'd97};
            6'h2e: rate_lut = {12'd768, 10'd129};
            6'h2f: rate_lut = {12'd960, 10'd129};
            6'h30: rate_lut = {12'd640, 10'd65};
            6'h31: rate_lut = {12'd768, 10'd65};
            6'h32: rate_lut = {12'd896, 10'd129};
            6'h33: rate_lut = {12'd1024, 10'd129};
            6'h34: rate_lut = {12'd1152, 10'd193};
            6'h35: rate_lut = {12'd1280, 10'd193};
            6'h36: rate_lut = {12'd1536, 10'd257};
            6'h37: rate_lut = {12'd1920, 10'd257};
            6'h38: rate_lut = {12'd1280, 10'd129};
            6'h39: rate_lut = {12'd1536, 10'd129};
            6'h3a: rate_lut = {12'd1792, 10'd257};
            6'h3b: rate_lut = {12'd2048, 10'd257};
            6'h3c: rate_lut = {12'd2304, 10'd385};
            6'h3d: rate_lut = {12'd2560, 10'd385};
            6'h3e: rate_lut = {12'd3072, 10'd513};
            default: rate_lut = {12'd3840, 10'd513};
        endcase
    endfunction

    always_comb
    begin
        rate = rate_lut(r.divider[RATE_HI:RATE_LO]);
        multiplier_select_sel = r.divider[MULTIPLIER_SELECT_HI:MULTIPLIER_SELECT_LO];
        case (multiplier_select_sel)
            MULTIPLIER_SELECT_X2: period = {1'b0, rate.divider, 1'b0};
            MULTIPLIER_SELECT_X4: period = {rate.divider, 2'b00};
            default: period = {2'b00, rate.divider};
        endcase
        half = {1'b0, period[13:1]};
        acc = (avs_read || avs_write) && !r.waitrequest;
        scl_rise = scl_in && !r.scl_q;
        scl_fall = !scl_in && r.scl_q;
        start_seen = scl_in && r.scl_q && r.sda_q && !sda_in;
        stop_seen = scl_in && r.scl_q && !r.sda_q && sda_in;
    end

    always_comb
    begin
        next_r = r;
        next_r.scl_q = scl_in;
        next_r.sda_q = sda_in;

        // one wait cycle, then accept
        next_r.waitrequest = !((avs_read || avs_write) && r.waitrequest);
        if ((avs_read || avs_write) && r.waitrequest)
        begin
            case (avs_address)
                OFS_OWN_ADDR: next_r.readdata = {24'h000000, r.own_addr};
                OFS_DIVIDER: next_r.readdata = {24'h000000, r.divider};
                OFS_CONTROL: next_r.readdata = {31'h00000000, r.clk_en};
                OFS_STATUS: next_r.readdata = {29'h00000000, r.busy, r.slave_rw, r.addressed};
                default: next_r.readdata = 32'h00000000;
            endcase
        end
        if (acc && avs_write && avs_byteenable[0])
        begin
            case (avs_address)
                OFS_OWN_ADDR: next_r.own_addr = avs_writedata[7:0];
                OFS_DIVIDER: next_r.divider = avs_writedata[7:0];
                OFS_CONTROL: next_r.clk_en = avs_writedata[CTL_CLK_EN];
                OFS_STATUS:
                begin
                    if (avs_writedata[STS_ADDRESSED])
                    begin
                        next_r.addressed = 1'b0;
                    end
                end
                default: next_r.clk_en = r.clk_en;
            endcase
        end

        if (!r.clk_en || r.bit_cnt >= period - 14'h0001)
        begin
            next_r.bit_cnt = 14'h0000;
        end
        else
        begin
            next_r.bit_cnt = r.bit_cnt + 14'h0001;
        end
        // clock pulled low or released
        // enable taken from next state so the first low phase is a full half
        next_r.scl_oe_n = !(next_r.clk_en && next_r.bit_cnt < half);

        if (start_seen)
        begin
            next_r.busy = 1'b1;
        end
        else if (stop_seen)
        begin
            next_r.busy = 1'b0;
        end

        case (r.state)
            I2CBR_IDLE:
            begin
                next_r.sda_oe_n = 1'b1;
            end
            I2CBR_ADDR:
            begin
                if (scl_rise && r.bits != ADDR_BITS)
                begin
                    next_r.shift = {r.shift[6:0], sda_in};
                    next_r.bits = r.bits + 4'h1;
                end
                else if (scl_fall && r.bits == ADDR_BITS)
                begin
                    if (r.shift[7:1] == r.own_addr[7:1])
                    begin
                        next_r.addressed = 1'b1;
                        next_r.slave_rw = r.shift[0];
                        next_r.hold_cnt = rate.hold;
                        next_r.state = I2CBR_ACK_HOLD;
                    end
                    else
                    begin
                        next_r.state = I2CBR_IDLE;
                    end
                end
            end
            I2CBR_ACK_HOLD:
            begin
                if (r.hold_cnt <= 10'h001)
                begin
                    next_r.sda_oe_n = 1'b0;
                    next_r.state = I2CBR_ACK;
                end
                else
                begin
                    next_r.hold_cnt = r.hold_cnt - 10'h001;
                end
            end
            I2CBR_ACK:
            begin
                if (scl_fall)
                begin
                    next_r.hold_cnt = rate.hold;
                    next_r.state = I2CBR_REL_HOLD;
                end
            end
            I2CBR_REL_HOLD:
            begin
                if (r.hold_cnt <= 10'h001)
                begin
                    next_r.sda_oe_n = 1'b1;
                    next_r.state = I2CBR_IDLE;
                end
                else
                begin
                    next_r.hold_cnt = r.hold_cnt - 10'h001;
                end
            end
            default:
            begin
                next_r.state = I2CBR_IDLE;
            end
        endcase

        if (start_seen)
        begin
            next_r.sda_oe_n = 1'b1;
            next_r.bits = 4'h0;
            next_r.state = I2CBR_ADDR;
        end
        else if (stop_seen)
        begin
            next_r.sda_oe_n = 1'b1;
            next_r.state = I2CBR_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '{own_addr: RST_OWN_ADDR, divider: RST_DIVIDER, clk_en: RST_CLK_EN,
                   waitrequest: 1'b1, readdata: 32'h00000000, bit_cnt: 14'h0000,
                   hold_cnt: 10'h000, scl_oe_n: 1'b1, sda_oe_n: 1'b1, scl_q: 1'b1,
                   sda_q: 1'b1, state: I2CBR_IDLE, shift: 8'h00, bits: 4'h0,
                   addressed: 1'b0, slave_rw: 1'b0, busy: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign avs_readdata = r.readdata;
    assign avs_waitrequest = r.waitrequest;
    assign scl_oe_n = r.scl_oe_n;
    assign sda_oe_n = r.sda_oe_n;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

endmodule

// ### rtl/i2cbr_pkg.sv
package i2cbr_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;

    // register byte addresses
    localparam logic [3:0] OFS_OWN_ADDR = 4'h0;
    localparam logic [3:0] OFS_DIVIDER = 4'h4;
    localparam logic [3:0] OFS_CONTROL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_DIVIDER = 8'h00;
    localparam logic RST_CLK_EN = 1'b0;

    // divider register fields
    localparam int unsigned MULTIPLIER_SELECT_HI = 7;
    localparam int unsigned MULTIPLIER_SELECT_LO = 6;
    localparam int unsigned RATE_HI = 5;
    localparam int unsigned RATE_LO = 0;
    localparam logic [1:0] MULTIPLIER_SELECT_X1 = 2'h0;
    localparam logic [1:0] MULTIPLIER_SELECT_X2 = 2'h1;
    localparam logic [1:0] MULTIPLIER_SELECT_X4 = 2'h2;

    // control and status bits
    localparam int unsigned CTL_CLK_EN = 0;
    localparam int unsigned STS_ADDRESSED = 0;
    localparam int unsigned STS_SLAVE_RW = 1;
    localparam int unsigned STS_BUSY = 2;

    localparam logic [3:0] ADDR_BITS = 4'h8;

    typedef enum logic [2:0] {
        I2CBR_IDLE = 3'b000,
        I2CBR_ADDR = 3'b001,
        I2CBR_ACK_HOLD = 3'b010,
        I2CBR_ACK = 3'b011,
        I2CBR_REL_HOLD = 3'b100
    } i2cbr_state_t;

    typedef struct packed {
        logic [11:0] divider;
        logic [9:0] hold;
    } i2cbr_rate_t;

    typedef struct packed {
        logic [7:0] own_addr;
        logic [7:0] divider;
        logic clk_en;
        logic waitrequest;
        logic [31:0] readdata;
        logic [13:0] bit_cnt;
        logic [9:0] hold_cnt;
        logic scl_oe_n;
        logic sda_oe_n;
        logic scl_q;
        logic sda_q;
        i2cbr_state_t state;
        logic [7:0] shift;
        logic [3:0] bits;
        logic addressed;
        logic slave_rw;
        logic busy;
    } i2cbr_regs_t;
endpackage

// ### test/i2cbr_chk.sv
`timescale 1ns/1ns
module i2cbr_chk
    import i2cbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_ack_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("wait low too long");
    property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_take: assert property (p_take) else $error("request not answered");
    property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_unmap; avs_read && avs_waitrequest && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold_rd; avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata); endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("read data moved");
    property p_upper; avs_readdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_open; scl_out == 1'b0 && sda_out == 1'b0; endproperty
    a_open: assert property (p_open) else $error("line driven high");
    property p_scl_low; $fell(scl_oe_n) |=> !scl_oe_n [*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low phase short");
    property p_sda_hold; $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 6); endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("data changed early");
    c_ack: cover property ($fell(sda_oe_n));
    c_gen: cover property ($fell(scl_oe_n));
    c_rd: cover property (avs_read && !avs_waitrequest);
endmodule

// ### test/i2cbr_peer.sv
`timescale 1ns/1ns
module i2cbr_peer
    import i2cbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    output logic scl_in,
    output logic sda_in
);
    logic scl_dn = 1'b0;
    logic sda_dn = 1'b0;
    assign scl_in = scl_oe_n & !scl_dn;
    assign sda_in = sda_oe_n & !sda_dn;
    task automatic put(input logic c, input logic d, input int n);
        scl_dn <= !c;
        sda_dn <= !d;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic send(input logic [7:0] b, input int h, output logic ack, output int hold);
        hold = 0;
        put(1, 0, h);
        for (int i = 7; i >= 0; i--)
        begin
            put(0, !sda_dn, 2);
            put(0, b[i], h - 2);
            put(1, b[i], h);
        end
        put(0, 1, 0);
        while (sda_oe_n !== 1'b0 && hold < h)
        begin
            @(posedge core_clk);
            hold++;
        end
        repeat (h - hold + 2) @(posedge core_clk);
        put(1, 1, h);
        ack = (sda_in === 1'b0);
        put(0, 1, h);
        put(0, 0, h);
        put(1, 0, h);
        put(1, 1, h);
    endtask
endmodule

// ### test/i2cbr_tb_top.sv
`timescale 1ns/1ns
module i2cbr_baud_and_slave_address_tb_top
    import i2cbr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 78752;
    int per[3] = '{20, 56, 192};
    always #20 core_clk = ~core_clk;
    i2cbr_top dut_u (.*);
    i2cbr_peer peer_u (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            print_verdict();
        end
    end
    always @(posedge core_clk)
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check(avs_readdata, exp_q.pop_front(), "readdata");
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'($random(seed)), d};
        avs_byteenable <= be;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00, 4'hf);
    endtask
    initial
    begin
        logic [7:0] v;
        logic ack;
        int hold, lo, hi;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(4'(i * 4), 32'h0);
        v = 8'($random(seed));
        bus(1'b1, OFS_OWN_ADDR, v, 4'hf);
        bus(1'b1, OFS_OWN_ADDR, ~v, 4'h0);
        bus(1'b1, 4'h6, ~v, 4'hf);
        rd(4'h6, 32'h0);
        rd(OFS_OWN_ADDR, {24'h0, v});
        $display("test registers done");
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, OFS_DIVIDER, {2'(i), 6'(i * 8)}, 4'hf);
            rd(OFS_DIVIDER, {24'h0, 2'(i), 6'(i * 8)});
            bus(1'b1, OFS_CONTROL, 8'h01, 4'hf);
            lo = 0;
            hi = 0;
            while (scl_oe_n === 1'b0) @(posedge core_clk);
            while (scl_oe_n === 1'b1) @(posedge core_clk);
            while (scl_oe_n === 1'b0)
            begin
                @(posedge core_clk);
                lo++;
            end
            while (scl_oe_n === 1'b1)
            begin
                @(posedge core_clk);
                hi++;
            end
            check(lo + hi, per[i], "period");
            check(lo, per[i] / 2, "low phase");
            // disable only in the high phase, so no low phase is cut short
            while (scl_oe_n === 1'b0) @(posedge core_clk);
            bus(1'b1, OFS_CONTROL, 8'h00, 4'hf);
        end
        $display("test clock generator done");
        bus(1'b1, OFS_DIVIDER, 8'h00, 4'hf);
        for (int i = 0; i < 2; i++)
        begin
            peer_u.send({v[7:1] ^ 7'(i), 1'b1}, 20, ack, hold);
            check(ack, !i, "ack");
            check(i || (hold >= 7 && hold <= 10), 1'b1, "hold");
            rd(OFS_STATUS, i ? 32'h2 : 32'h3);
            bus(1'b1, OFS_STATUS, 8'h01, 4'hf);
        end
        bus(1'b1, OFS_DIVIDER, 8'h3f, 4'hf);
        peer_u.send({v[7:1], 1'b0}, 600, ack, hold);
        check(ack, 1'b1, "ack long");
        check(hold >= 513 && hold <= 516, 1'b1, "hold long");
        $display("test slave address done");
        print_verdict();
    end
endmodule
bind i2cbr_top i2cbr_chk chk_u (.*);
